/* File: core/mode_command_select.v */
// Function
// RULE1: Torque percent equals volts times scale over ten.
// RULE2: Full scale 16-bit, range 0..1000, default 100.
// RULE3: Scale sets torque command or torque limit.
// RULE4: First torque: zero mode zero, else analog.
// RULE5: Torque select honoured only after servo-on; the TORQUE_PERCENT_O zeroing uses it before servo-on too.
// RULE6: Dual codes 06 to 0A choose by inputs.
// RULE7: Codes 0D, 0E, 0F choose sub-mode by inputs.
// RULE8: No zero-speed or zero-torque combinations.
// RULE9: Pulse or table source for position.
// RULE10: Speed from analog or three internal values.
// RULE11: Speed switch on runs speed, ignores trigger.
// RULE12: Switch off stops until trigger rises.
// RULE13: Trigger rise latches six-bit index, moves.
// RULE14: Speed switch on again returns speed.
// RULE15: Torque switch on runs torque command.
// RULE16: Torque switch off follows speed command.
// RULE17: Torque switch on again returns torque.
// RULE18: Input low is open, high is closed.
// RULE19: Nonzero torque select picks internal value.
// RULE20: Inputs synchronised before edges and modes.
`timescale 1ns/10ps
`include "mode_select_consts.vh"

module mode_command_select #(
  parameter AIN_W = 16  // Signed analog input in millivolts.
) (
  // Clock and reset.
  input  wire              MCLK_I,
  input  wire              RST_I,
  // AXI4-Lite write address and data.
  input  wire [11:0]       AWADDR_I,
  input  wire              AWVALID_I,
  output reg               AWREADY_O,
  input  wire [31:0]       WDATA_I,
  input  wire [3:0]        WSTRB_I,
  input  wire              WVALID_I,
  output reg               WREADY_O,
  // AXI4-Lite write response.
  output reg  [1:0]        BRESP_O,
  output reg               BVALID_O,
  input  wire              BREADY_I,
  // AXI4-Lite read channels.
  input  wire [11:0]       ARADDR_I,
  input  wire              ARVALID_I,
  output reg               ARREADY_O,
  output reg  [31:0]       RDATA_O,
  output reg  [1:0]        RRESP_O,
  output reg               RVALID_O,
  input  wire              RREADY_I,
  // Digital inputs from the motion controller.
  input  wire [1:0]        TORQUE_CMD_SELECT_I,
  input  wire [1:0]        SPEED_CMD_SELECT_I,
  input  wire [5:0]        POSITION_INDEX_SELECT_I,
  input  wire              POSITION_TRIGGER_I,
  input  wire              SPEED_POS_SWITCH_I,
  input  wire              SPEED_TORQUE_SWITCH_I,
  input  wire              POS_SOURCE_SWITCH_I,
  // Analog torque reference in millivolts.
  input  wire [AIN_W-1:0]  ANALOG_TORQUE_I,
  // Selection results.
  output reg  [2:0]        ACTIVE_MODE_O,
  output reg  [1:0]        TORQUE_SOURCE_O,
  output reg  [1:0]        SPEED_SOURCE_O,
  output reg  [5:0]        POSITION_INDEX_O,
  output reg               MOVE_START_O,
  output reg  [31:0]       TORQUE_PERCENT_O,
  output reg               TORQUE_IS_LIMIT_O
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Tells whether a mode code is one of the accepted combinations.
  function code_ok;
    input [7:0] c;
    begin
      code_ok = (c >= `CODE_PT_S && c <= `CODE_S_T) ||
                (c >= `CODE_PT_PR && c <= `CODE_PT_PR_T); // RULE6 RULE7 RULE8
    end
  endfunction

  // Picks the position sub-mode from the code and source switch.
  function [2:0] pos_kind;
    input [7:0] c;
    input       table_sel;
    begin
      if (c == `CODE_PR_S || c == `CODE_PR_T) begin
        pos_kind = `ACT_TABLE_POS; // RULE9
      end else if (c >= `CODE_PT_PR) begin
        pos_kind = table_sel ? `ACT_TABLE_POS : `ACT_PULSE_POS; // RULE7
      end else begin
        pos_kind = `ACT_PULSE_POS; // RULE9
      end
    end
  endfunction

  // ****************************************************************
  // Registers and synchronisers.
  // ****************************************************************
  reg  [15:0] full_scale_ff;   // Analog torque full scale, percent.
  reg  [7:0]  mode_code_ff;    // Selected combination code.
  reg         zero_torque_ff;  // First torque command forced to zero.
  reg         servo_on_ff;     // Servo enabled.
  reg  [13:0] sync1_ff;        // First synchroniser stage.
  reg  [13:0] sync2_ff;        // Second synchroniser stage.
  reg         trig_prev_ff;    // Trigger value one cycle ago.
  reg         pos_armed_ff;    // Position command latched.
  reg         aw_got_ff;       // Write address held.
  reg         w_got_ff;        // Write data held.
  reg  [11:0] aw_addr_ff;      // Captured write address.
  reg  [31:0] w_data_ff;       // Captured write data.
  reg  [3:0]  w_strb_ff;       // Captured byte strobes.

  wire [13:0] raw_in = {POS_SOURCE_SWITCH_I, SPEED_TORQUE_SWITCH_I,
                        SPEED_POS_SWITCH_I, POSITION_TRIGGER_I,
                        POSITION_INDEX_SELECT_I, SPEED_CMD_SELECT_I,
                        TORQUE_CMD_SELECT_I};

  // Two flops per input; only the second stage feeds logic.
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1_ff <= 14'h0000;
      sync2_ff <= 14'h0000;
    end else begin
      sync1_ff <= raw_in; // RULE20
      sync2_ff <= sync1_ff;
    end
  end

  // Synchronised input fields; high means closed contact.
  wire [1:0] tsel    = sync2_ff[1:0];   // RULE18
  wire [1:0] ssel    = sync2_ff[3:2];
  wire [5:0] pidx    = sync2_ff[9:4];
  wire       trig    = sync2_ff[10];
  wire       sp_on   = sync2_ff[11];
  wire       st_on   = sync2_ff[12];
  wire       tbl_sel = sync2_ff[13];
  wire       trig_rise = trig & ~trig_prev_ff;

  // ****************************************************************
  // Mode selection.
  // ****************************************************************
  reg [2:0] nxt_active;  // Next active sub-mode.
  reg       pos_combo;   // Code includes a position mode (06 to 09, 0D to 0F).
  reg       other_on;    // Partner switch closed.
  reg [2:0] other_mode;  // Partner mode, speed or torque.

  // Evaluates the active sub-mode from code and switch inputs.
  always @* begin
    pos_combo  = 1'b1;
    other_on   = 1'b0;
    other_mode = `ACT_SPEED;
    nxt_active = `ACT_STOP;
    case (mode_code_ff)
      `CODE_PT_S, `CODE_PR_S, `CODE_POS_POS_SPEED_MULTI: begin
        other_on   = sp_on; // RULE11
        other_mode = `ACT_SPEED;
      end
      `CODE_PT_T, `CODE_PR_T, `CODE_PT_PR_T: begin
        other_on   = st_on;
        other_mode = `ACT_TORQUE;
      end
      `CODE_PT_PR: begin
        other_on = 1'b0;
      end
      default: begin
        pos_combo = 1'b0;
      end
    endcase
    if (!servo_on_ff || !code_ok(mode_code_ff)) begin
      nxt_active = `ACT_STOP;
    end else if (!pos_combo) begin
      // Speed/torque pair switches at once both ways.
      nxt_active = st_on ? `ACT_TORQUE : `ACT_SPEED; // RULE15 RULE16 RULE17
    end else if (other_on) begin
      nxt_active = other_mode; // RULE11 RULE14
    end else if (pos_armed_ff || trig_rise) begin
      nxt_active = pos_kind(mode_code_ff, tbl_sel); // RULE13
    end else begin
      nxt_active = `ACT_STOP; // RULE12
    end
  end

  // Position arming: cleared whenever the partner mode runs.
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      trig_prev_ff     <= 1'b0;
      pos_armed_ff     <= 1'b0;
      POSITION_INDEX_O <= 6'h00;
      MOVE_START_O     <= 1'b0;
    end else begin
      trig_prev_ff <= trig;
      MOVE_START_O <= 1'b0;
      if (!servo_on_ff || !pos_combo || other_on) begin
        pos_armed_ff <= 1'b0; // RULE11 RULE12
      end else if (trig_rise) begin
        pos_armed_ff     <= 1'b1;
        POSITION_INDEX_O <= pidx; // RULE13
        MOVE_START_O     <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Command sources and torque scaling.
  // ****************************************************************
  wire signed [AIN_W-1:0] ain_s = ANALOG_TORQUE_I;
  wire signed [AIN_W+17:0] prod = ain_s * $signed({2'b00, full_scale_ff});
  // Millivolts times percent over 10000 gives percent of rated torque.
  wire signed [AIN_W+17:0] pct  = prod / $signed(34'sd10000); // RULE1

  // Registers the sources and scaled torque each cycle.
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ACTIVE_MODE_O     <= `ACT_STOP;
      TORQUE_SOURCE_O   <= `SRC_ANALOG;
      SPEED_SOURCE_O    <= `SRC_ANALOG;
      TORQUE_PERCENT_O  <= 32'h00000000;
      TORQUE_IS_LIMIT_O <= 1'b0;
    end else begin
      ACTIVE_MODE_O <= nxt_active;
      if (!servo_on_ff) begin
        TORQUE_SOURCE_O <= zero_torque_ff ? `SRC_ZERO : `SRC_ANALOG; // RULE5
      end else if (tsel != 2'b00) begin
        TORQUE_SOURCE_O <= tsel; // RULE19
      end else begin
        TORQUE_SOURCE_O <= zero_torque_ff ? `SRC_ZERO : `SRC_ANALOG; // RULE4
      end
      SPEED_SOURCE_O <= ssel; // RULE10
      if (zero_torque_ff && tsel == 2'b00) begin
        TORQUE_PERCENT_O <= 32'h00000000; // RULE4
      end else begin
        TORQUE_PERCENT_O <= pct[31:0];
      end
      TORQUE_IS_LIMIT_O <= (nxt_active != `ACT_TORQUE); // RULE3
    end
  end

  // ****************************************************************
  // AXI4-Lite slave.
  // ****************************************************************
  wire do_write = aw_got_ff && w_got_ff && !BVALID_O;
  wire wr_fs    = (aw_addr_ff == `FS_ADDR);
  wire wr_mode  = (aw_addr_ff == `MODE_ADDR);
  wire wr_ctrl  = (aw_addr_ff == `CTRL_ADDR);
  wire wr_hit   = wr_fs | wr_mode | wr_ctrl;
  wire [15:0] fs_new = {w_strb_ff[1] ? w_data_ff[15:8] : full_scale_ff[15:8],
                        w_strb_ff[0] ? w_data_ff[7:0] : full_scale_ff[7:0]};

  // Takes address and data in either order, then answers.
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      AWREADY_O      <= 1'b0;
      WREADY_O       <= 1'b0;
      BVALID_O       <= 1'b0;
      BRESP_O        <= 2'b00;
      aw_got_ff      <= 1'b0;
      w_got_ff       <= 1'b0;
      aw_addr_ff     <= 12'h000;
      w_data_ff      <= 32'h00000000;
      w_strb_ff      <= 4'h0;
      full_scale_ff  <= `FS_RESET;
      mode_code_ff   <= `MODE_RESET;
      zero_torque_ff <= 1'b0;
      servo_on_ff    <= 1'b0;
    end else begin
      AWREADY_O <= !aw_got_ff && !AWREADY_O && AWVALID_I;
      WREADY_O  <= !w_got_ff && !WREADY_O && WVALID_I;
      if (AWREADY_O && AWVALID_I) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= AWADDR_I;
      end
      if (WREADY_O && WVALID_I) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= WDATA_I;
        w_strb_ff <= WSTRB_I;
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        BVALID_O  <= 1'b1;
        BRESP_O   <= wr_hit ? 2'b00 : 2'b10;
        if (wr_fs && fs_new <= `FS_MAX) begin
          full_scale_ff <= fs_new; // RULE2
        end
        if (wr_mode && w_strb_ff[0] && code_ok(w_data_ff[7:0])) begin
          mode_code_ff <= w_data_ff[7:0]; // RULE6 RULE7 RULE8
        end
        if (wr_ctrl && w_strb_ff[0]) begin
          zero_torque_ff <= w_data_ff[`CTRL_ZT_BIT];
          servo_on_ff    <= w_data_ff[`CTRL_SON_BIT];
        end
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end

  // Read path: one cycle to accept, data the next.
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h00000000;
      RRESP_O   <= 2'b00;
    end else begin
      ARREADY_O <= !ARREADY_O && !RVALID_O && ARVALID_I;
      if (ARREADY_O && ARVALID_I) begin
        RVALID_O <= 1'b1;
        RRESP_O  <= 2'b00;
        case (ARADDR_I)
          `FS_ADDR:   RDATA_O <= {16'h0000, full_scale_ff};
          `MODE_ADDR: RDATA_O <= {24'h000000, mode_code_ff};
          `CTRL_ADDR: RDATA_O <= {30'h00000000, servo_on_ff,
                                  zero_torque_ff};
          `STAT_ADDR: RDATA_O <= {16'h0000, POSITION_INDEX_O, 3'h0,
                                  pos_armed_ff, 3'h0, ACTIVE_MODE_O};
          `TCMD_ADDR: RDATA_O <= TORQUE_PERCENT_O;
          `SCMD_ADDR: RDATA_O <= {28'h0000000, SPEED_SOURCE_O,
                                  TORQUE_SOURCE_O};
          default: begin
            RDATA_O <= 32'h00000000;
            RRESP_O <= 2'b10;
          end
        endcase
      end else if (RVALID_O && RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end
  end

endmodule

/* File: inc/mode_select_consts.vh */
`ifndef MODE_SELECT_CONSTS_VH
`define MODE_SELECT_CONSTS_VH

// ****************************************************************
// Register byte addresses.
// ****************************************************************
// Full-scale word sits at word index 0x152; its byte address is four times.
`define FS_IDX          12'h152
`define FS_ADDR         12'h548
`define MODE_ADDR       12'h000
`define CTRL_ADDR       12'h004
`define STAT_ADDR       12'h008
`define TCMD_ADDR       12'h00C
`define SCMD_ADDR       12'h010

// ****************************************************************
// Reset values and limits.
// ****************************************************************
`define FS_RESET        16'h0064
`define FS_MAX          16'h03E8
`define FS_DIVISOR      8'h0A
`define MODE_RESET      8'h00

// ****************************************************************
// Control mode codes.
// ****************************************************************
`define CODE_PT_S       8'h06
`define CODE_PT_T       8'h07
`define CODE_PR_S       8'h08
`define CODE_PR_T       8'h09
`define CODE_S_T        8'h0A
`define CODE_PT_PR      8'h0D
`define CODE_POS_POS_SPEED_MULTI    8'h0E
`define CODE_PT_PR_T    8'h0F

// ****************************************************************
// Active sub-mode encodings and source encodings.
// ****************************************************************
`define ACT_STOP        3'h0
`define ACT_PULSE_POS   3'h1
`define ACT_TABLE_POS   3'h2
`define ACT_SPEED       3'h3
`define ACT_TORQUE      3'h4

`define SRC_ANALOG      2'h0
`define SRC_ZERO        2'h3

// ****************************************************************
// Field positions.
// ****************************************************************
`define CTRL_ZT_BIT     0
`define CTRL_SON_BIT    1

`endif

/* File: dv/mode_select_chk.sv */
`timescale 1ns/10ps
`include "mode_select_consts.vh"
// ****
// Watches mode outputs, move starts and write answers.
// ****
module mode_select_chk (
  // Clock and reset.
  input wire        MCLK_I,
  input wire        RST_I,
  // Write answer.
  input wire        BVALID_O,
  input wire [1:0]  BRESP_O,
  // Host levels and selection results.
  input wire [1:0]  SPEED_CMD_SELECT_I,
  input wire [5:0]  POSITION_INDEX_SELECT_I,
  input wire        POSITION_TRIGGER_I,
  input wire [2:0]  ACTIVE_MODE_O,
  input wire [1:0]  SPEED_SOURCE_O,
  input wire [5:0]  POSITION_INDEX_O,
  input wire        MOVE_START_O,
  input wire        TORQUE_IS_LIMIT_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // A move needs a synchronised trigger rise three edges back.
  move_cause_a: assert property (
    MOVE_START_O |-> $past(POSITION_TRIGGER_I, 3)
    && !$past(POSITION_TRIGGER_I, 4)) else $error("Move without rise.");
  index_latch_a: assert property (
    MOVE_START_O |-> POSITION_INDEX_O == $past(POSITION_INDEX_SELECT_I, 3))
    else $error("Wrong index latched.");
  move_pulse_a: assert property (
    MOVE_START_O |=> !MOVE_START_O) else $error("Move start too long.");
  move_mode_a: assert property (
    MOVE_START_O |-> ACTIVE_MODE_O inside {`ACT_PULSE_POS, `ACT_TABLE_POS})
    else $error("Move outside position mode.");
  torque_cmd_a: assert property (
    ACTIVE_MODE_O == `ACT_TORQUE |-> !TORQUE_IS_LIMIT_O)
    else $error("Torque mode flagged as limit.");
  torque_limit_a: assert property (
    ACTIVE_MODE_O inside {[3'h1:3'h3]} |-> TORQUE_IS_LIMIT_O)
    else $error("Limit flag missing.");
  speed_src_a: assert property (
    ACTIVE_MODE_O == `ACT_SPEED |-> SPEED_SOURCE_O == $past(SPEED_CMD_SELECT_I, 3))
    else $error("Speed source wrong.");
  bresp_code_a: assert property (
    BVALID_O |-> BRESP_O == 2'h0 || BRESP_O == 2'h2)
    else $error("Illegal write response.");
  cover property (MOVE_START_O);
  cover property (ACTIVE_MODE_O == `ACT_TORQUE);
  cover property (ACTIVE_MODE_O == `ACT_SPEED);
  cover property (BVALID_O && BRESP_O == 2'h2);
endmodule
bind mode_command_select mode_select_chk u_chk (
  .MCLK_I, .RST_I, .BVALID_O, .BRESP_O, .SPEED_CMD_SELECT_I,
  .POSITION_INDEX_SELECT_I, .POSITION_TRIGGER_I, .ACTIVE_MODE_O,
  .SPEED_SOURCE_O, .POSITION_INDEX_O, .MOVE_START_O, .TORQUE_IS_LIMIT_O);

/* File: dv/host_ctrl_model.sv */
`timescale 1ns/10ps
// ****
// Motion controller levels; high is ON, the closed contact.
// ****
module host_ctrl_model (
  // Clock.
  input  wire       clk_i,
  // Select, switch and trigger levels.
  output reg  [1:0] tsel_o = 2'h0,
  output reg  [1:0] ssel_o = 2'h0,
  output reg        sp_o   = 1'b0,
  output reg        st_o   = 1'b0,
  output reg        psrc_o = 1'b0,
  output reg  [5:0] idx_o  = 6'h00,
  output reg        trig_o = 1'b0
);
  // Sets torque, speed selects and the three switches after an edge.
  task automatic drive(input [6:0] lv);
    @(posedge clk_i);
    {tsel_o, ssel_o, sp_o, st_o, psrc_o} <= lv;
  endtask
  // Index goes out first and settles before the trigger rises.
  task automatic fire(input [5:0] idx, input int gap);
    @(posedge clk_i);
    idx_o <= idx;
    repeat (gap + 2) @(posedge clk_i);
    trig_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    trig_o <= 1'b0;
  endtask
endmodule

/* File: dv/servo_mode_command_select_bench.sv */
`timescale 1ns/10ps
`include "mode_select_consts.vh"
module servo_mode_command_select_bench;
  // Inputs to the block, named as its ports.
  logic        MCLK_I = 1'b0, RST_I = 1'b1;
  logic [11:0] AWADDR_I = 12'h000, ARADDR_I = 12'h000;
  logic        AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
  logic        ARVALID_I = 1'b0, RREADY_I = 1'b0;
  logic [31:0] WDATA_I = 32'h0;
  logic [3:0]  WSTRB_I = 4'hF;
  logic [15:0] ANALOG_TORQUE_I = 16'h0000;
  wire         AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  wire  [1:0]  BRESP_O, RRESP_O, TORQUE_CMD_SELECT_I, SPEED_CMD_SELECT_I;
  wire  [1:0]  TORQUE_SOURCE_O, SPEED_SOURCE_O;
  wire  [5:0]  POSITION_INDEX_SELECT_I, POSITION_INDEX_O;
  wire         POSITION_TRIGGER_I, SPEED_POS_SWITCH_I, MOVE_START_O;
  wire         SPEED_TORQUE_SWITCH_I, POS_SOURCE_SWITCH_I, TORQUE_IS_LIMIT_O;
  wire  [2:0]  ACTIVE_MODE_O;
  wire  [31:0] RDATA_O, TORQUE_PERCENT_O;
  int          fails = 0, samples_checked = 0, moves = 0;
  integer      seed = 32'h829ED07F;
  logic [7:0]  codes [8] = '{8'h06, 8'h07, 8'h08, 8'h09,
                             8'h0A, 8'h0D, 8'h0E, 8'h0F};
  logic [7:0]  pcodes [4] = '{8'h06, 8'h08, 8'h0E, 8'h07};

  mode_command_select u_dut (
    .MCLK_I(MCLK_I), .RST_I(RST_I),
    .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
    .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O),
    .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I),
    .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O),
    .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .TORQUE_CMD_SELECT_I(TORQUE_CMD_SELECT_I),
    .SPEED_CMD_SELECT_I(SPEED_CMD_SELECT_I),
    .POSITION_INDEX_SELECT_I(POSITION_INDEX_SELECT_I),
    .POSITION_TRIGGER_I(POSITION_TRIGGER_I),
    .SPEED_POS_SWITCH_I(SPEED_POS_SWITCH_I),
    .SPEED_TORQUE_SWITCH_I(SPEED_TORQUE_SWITCH_I),
    .POS_SOURCE_SWITCH_I(POS_SOURCE_SWITCH_I),
    .ANALOG_TORQUE_I(ANALOG_TORQUE_I), .ACTIVE_MODE_O(ACTIVE_MODE_O),
    .TORQUE_SOURCE_O(TORQUE_SOURCE_O), .SPEED_SOURCE_O(SPEED_SOURCE_O),
    .POSITION_INDEX_O(POSITION_INDEX_O), .MOVE_START_O(MOVE_START_O),
    .TORQUE_PERCENT_O(TORQUE_PERCENT_O),
    .TORQUE_IS_LIMIT_O(TORQUE_IS_LIMIT_O));
  host_ctrl_model u_host (
    .clk_i(MCLK_I), .tsel_o(TORQUE_CMD_SELECT_I), .ssel_o(SPEED_CMD_SELECT_I),
    .sp_o(SPEED_POS_SWITCH_I), .st_o(SPEED_TORQUE_SWITCH_I),
    .psrc_o(POS_SOURCE_SWITCH_I), .idx_o(POSITION_INDEX_SELECT_I),
    .trig_o(POSITION_TRIGGER_I));

  // ****
  // Clock, reset and move pulse counter.
  // ****
  always #10 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) if (MOVE_START_O === 1'b1) moves <= moves + 1;

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("Checked %0d, mismatches %0d.", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Compares a value seen with the value expected.
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // A wait that ran out of its bound is a failure.
  task automatic tmo(input int n);
    if (n >= 40) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK_I);
  endtask
  // Bus write: each channel dropped as soon as it is taken.
  task automatic wr(input [11:0] a, input [31:0] d, output [1:0] r);
    int n = 0;
    @(posedge MCLK_I);
    {AWADDR_I, WDATA_I} <= {a, d};
    {AWVALID_I, WVALID_I, BREADY_I} <= 3'b111;
    do begin
      @(posedge MCLK_I);
      n++;
      if (AWREADY_O === 1'b1) AWVALID_I <= 1'b0;
      if (WREADY_O === 1'b1) WVALID_I <= 1'b0;
    end while (BVALID_O !== 1'b1 && n < 40);
    BREADY_I <= 1'b0;
    r = BRESP_O;
    tmo(n);
  endtask
  // Bus read.
  task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
    int n = 0;
    @(posedge MCLK_I);
    ARADDR_I <= a;
    {ARVALID_I, RREADY_I} <= 2'b11;
    do begin
      @(posedge MCLK_I);
      n++;
      if (ARREADY_O === 1'b1) ARVALID_I <= 1'b0;
    end while (RVALID_O !== 1'b1 && n < 40);
    RREADY_I <= 1'b0;
    {d, r} = {RDATA_O, RRESP_O};
    tmo(n);
  endtask
  // Percent of rated torque from millivolts and the full-scale word.
  function automatic logic [31:0] pct(input int v, input int f);
    pct = (v * f) / 10000;
  endfunction

  // ****
  // Main sequence.
  // ****
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          mv, fs;
    cyc(5);
    RST_I <= 1'b0;
    rd(`FS_ADDR, d, r);
    chk("fs reset", d, 32'h64);
    wr(`FS_ADDR, 32'd1001, r);
    rd(`FS_ADDR, d, r);
    chk("fs range", d, 32'h64);
    // A write with no byte strobes leaves the full-scale word alone.
    WSTRB_I <= 4'h0;
    wr(`FS_ADDR, 32'h1F4, r);
    rd(`FS_ADDR, d, r);
    chk("fs strobe", d, 32'h64);
    WSTRB_I <= 4'hF;
    wr(12'h100, 32'h1, r);
    chk("wr unmapped", r, 2'h2);
    rd(12'h104, d, r);
    chk("rd unmapped", r, 2'h2);
    foreach (codes[i]) begin
      wr(`MODE_ADDR, codes[i], r);
      rd(`MODE_ADDR, d, r);
      chk("mode code", d, codes[i]);
    end
    wr(`MODE_ADDR, 32'h0B, r);
    rd(`MODE_ADDR, d, r);
    chk("no zero combo", d, 32'h0F);
    $display("Registers and codes done.");
    // Speed/torque combination, torque switch ON, corners then random.
    wr(`MODE_ADDR, 32'h0A, r);
    wr(`CTRL_ADDR, 32'h2, r);
    u_host.drive(7'b0000010);
    for (int i = 0; i < 6; i++) begin
      fs = (i < 3) ? 1000 * (i % 2) : {$random(seed)} % 1001;
      mv = (i < 3) ? 10000 - 20000 * (i % 2) : $random(seed) % 10001;
      wr(`FS_ADDR, fs, r);
      ANALOG_TORQUE_I <= mv[15:0];
      cyc(6);
      chk("torque mode", ACTIVE_MODE_O, `ACT_TORQUE);
      chk("cmd flag", TORQUE_IS_LIMIT_O, 1'b0);
      chk("torque pct", TORQUE_PERCENT_O, pct(mv, fs));
    end
    for (int s = 0; s < 4; s++) begin
      u_host.drive({2'b00, s[1:0], 3'b000});
      cyc(4);
      chk("speed mode", ACTIVE_MODE_O, `ACT_SPEED);
      chk("speed src", SPEED_SOURCE_O, s);
      chk("limit flag", TORQUE_IS_LIMIT_O, 1'b1);
    end
    u_host.drive(7'b0000010);
    cyc(4);
    chk("back torque", ACTIVE_MODE_O, `ACT_TORQUE);
    // Torque source before and after servo-on.
    wr(`CTRL_ADDR, 32'h0, r);
    u_host.drive(7'b1000010);
    cyc(4);
    chk("pre servo", TORQUE_SOURCE_O, `SRC_ANALOG);
    wr(`CTRL_ADDR, 32'h2, r);
    for (int t = 1; t < 4; t++) begin
      u_host.drive({t[1:0], 5'b00010});
      cyc(4);
      chk("tq src", TORQUE_SOURCE_O, t);
    end
    u_host.drive(7'b0000010);
    wr(`CTRL_ADDR, 32'h3, r);
    cyc(4);
    chk("zero tq", TORQUE_SOURCE_O, `SRC_ZERO);
    chk("zero pct", TORQUE_PERCENT_O, 32'h0);
    $display("Speed and torque selection done.");
    // Speed/position combinations with trigger-gated moves.
    wr(`CTRL_ADDR, 32'h2, r);
    wr(`MODE_ADDR, 32'h06, r);
    u_host.drive(7'b0000100);
    cyc(4);
    chk("sp speed", ACTIVE_MODE_O, `ACT_SPEED);
    mv = moves;
    u_host.fire(6'h15, 1);
    chk("trig ignored", moves - mv, 0);
    u_host.drive(7'b0000000);
    cyc(4);
    chk("stopped", ACTIVE_MODE_O, `ACT_STOP);
    // Codes 06, 08, 0E (table source chosen) and 07 with a torque partner.
    for (int k = 0; k < 4; k++) begin
      wr(`MODE_ADDR, pcodes[k], r);
      u_host.drive({6'b000000, k == 2});
      fs = $random(seed) & 63;
      mv = moves;
      u_host.fire(fs[5:0], k * 3);
      chk("move pulse", moves - mv, 1);
      chk("index", POSITION_INDEX_O, fs[5:0]);
      chk("pos src", ACTIVE_MODE_O, (k % 3) ? 3'h2 : 3'h1);
      u_host.drive(k == 3 ? 7'b0000010 : 7'b0000100);
      cyc(4);
      chk("resume", ACTIVE_MODE_O,
          k == 3 ? `ACT_TORQUE : `ACT_SPEED);
    end
    $display("Position switching done.");
    end_sim();
  end
endmodule
